// ### hw/bmf_pkg.sv
`default_nettype none
package bmf_pkg;
    localparam int DATA_W     = 18;
    localparam int BYTE_W     = 9;
    localparam int DEPTH      = 16;
    localparam int AW         = 4;
    localparam int HALF_LVL   = 8;
    localparam int AE_OFS     = 2;
    localparam int AF_OFS     = 2;
    localparam int FALL_EDGES = 3;

    // Pin group sampled together so that data stays aligned with its strobe.
    typedef struct packed {
        logic              wclk;
        logic              wr_strobe;
        logic              write_enable_n;
        logic              rclk;
        logic              rd_strobe;
        logic              read_enable_n;
        logic              read_chip_select_n;
        logic              master_reset_n;
        logic              partial_reset_n;
        logic              input_width_select;
        logic              output_width_select;
        logic              fallthrough_mode_serial_in;
        logic              async_write_sel;
        logic              async_read_sel;
        logic [DATA_W-1:0] data;
    } bmf_pins_t;

    // Configuration caught at master reset.
    typedef struct packed {
        logic in_x9;
        logic out_x9;
        logic fall_thru;
        logic async_w;
        logic async_r;
    } bmf_cfg_t;

    localparam bmf_cfg_t CFG_RST = '{in_x9: 1'b0, out_x9: 1'b0, fall_thru: 1'b0, async_w: 1'b0, async_r: 1'b0};
    localparam bmf_pins_t PINS_RST = '{wclk: 1'b0, wr_strobe: 1'b0, write_enable_n: 1'b1, rclk: 1'b0,
        rd_strobe: 1'b0, read_enable_n: 1'b1, read_chip_select_n: 1'b1, master_reset_n: 1'b1,
        partial_reset_n: 1'b1, input_width_select: 1'b0, output_width_select: 1'b0,
        fallthrough_mode_serial_in: 1'b0, async_write_sel: 1'b0, async_read_sel: 1'b0, data: '0};
endpackage
`default_nettype wire

// ### hw/bmf_fifo.sv
`timescale 1ns/1ns
`default_nettype none

// Storage buffer with valid and ready on both sides; clear flushes the pointers.
module bmf_buf #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             clear,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [AW:0]           level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    logic             push;
    logic             pop;

    // Full and empty come straight from the pointer distance.
    assign level     = wp_r - rp_r;
    assign in_ready  = (level != (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data  = mem[rp_r[AW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers; a refused push or pop leaves everything untouched.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
        end else if (clear) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    // Storage array needs no reset; stale words are never presented as valid.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule

module bmf_fifo (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    input  wire logic                      wclk,
    input  wire logic                      wr_strobe,
    input  wire logic                      write_enable_n,
    input  wire logic [bmf_pkg::DATA_W-1:0] write_data_bus,
    input  wire logic                      rclk,
    input  wire logic                      rd_strobe,
    input  wire logic                      read_enable_n,
    input  wire logic                      read_chip_select_n,
    input  wire logic                      output_enable_n,
    input  wire logic                      master_reset_n,
    input  wire logic                      partial_reset_n,
    input  wire logic                      input_width_select,
    input  wire logic                      output_width_select,
    input  wire logic                      fallthrough_mode_serial_in,
    input  wire logic                      async_write_sel,
    input  wire logic                      async_read_sel,
    output logic [bmf_pkg::DATA_W-1:0]     read_data_bus,
    output logic                           read_data_bus_oe,
    output logic                           echo_read_enable_n,
    output logic                           echo_read_clock,
    output logic                           empty_flag_out_valid,
    output logic                           full_flag_in_ready,
    output logic                           half_full_flag,
    output logic                           almost_empty_flag,
    output logic                           almost_full_flag
);
    import bmf_pkg::*;

    bmf_pins_t         raw;
    bmf_pins_t         s1_r;
    bmf_pins_t         p;
    bmf_pins_t         d_r;
    bmf_cfg_t          cfg_r;
    logic              mclr;
    logic              clr;
    logic              rclk_rise;
    logic              wr_ev;
    logic              rd_ev;
    logic              whalf_r;
    logic [BYTE_W-1:0] wlo_r;
    logic              push_v;
    logic [DATA_W-1:0] push_d;
    logic              in_ready;
    logic              avail;
    logic [DATA_W-1:0] word;
    logic [AW:0]       level;
    logic              rhalf_r;
    logic              ov_r;
    logic [1:0]        fall_cnt_r;
    logic              take;
    logic              pop;
    logic [DATA_W-1:0] unit;
    logic              sel_n_r;

    assign raw = '{wclk: wclk, wr_strobe: wr_strobe, write_enable_n: write_enable_n, rclk: rclk,
        rd_strobe: rd_strobe, read_enable_n: read_enable_n, read_chip_select_n: read_chip_select_n,
        master_reset_n: master_reset_n, partial_reset_n: partial_reset_n,
        input_width_select: input_width_select, output_width_select: output_width_select,
        fallthrough_mode_serial_in: fallthrough_mode_serial_in, async_write_sel: async_write_sel,
        async_read_sel: async_read_sel, data: write_data_bus};

    // Both port clocks are sampled as plain pins into sys_clk, so pointers and flags
    // live in one domain and no pointer has to cross; the price is that each port
    // clock must stay well below a third of the system clock.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= PINS_RST;
            p    <= PINS_RST;
            d_r  <= PINS_RST;
        end else begin
            s1_r <= raw;
            p    <= s1_r;
            d_r  <= p;
        end
    end

    // Reset levels and edge events on the synchronised pins.
    assign mclr      = ~p.master_reset_n;
    assign clr       = mclr | ~p.partial_reset_n;
    assign rclk_rise = p.rclk & ~d_r.rclk;
    assign wr_ev     = cfg_r.async_w ? (p.wr_strobe & ~d_r.wr_strobe)
                                     : (p.wclk & ~d_r.wclk & ~p.write_enable_n);
    assign rd_ev     = cfg_r.async_r ? (p.rd_strobe & ~d_r.rd_strobe)
                                     : (rclk_rise & ~p.read_enable_n);

    // Configuration is caught only during master reset, so partial reset keeps it.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r <= CFG_RST;
        end else if (mclr) begin
            cfg_r.in_x9     <= p.input_width_select;
            cfg_r.out_x9    <= p.output_width_select;
            cfg_r.fall_thru <= p.fallthrough_mode_serial_in;
            cfg_r.async_w <= p.async_write_sel;
            cfg_r.async_r <= p.async_read_sel;
        end
    end

    // A 9-bit writer fills the low byte first; the pair is stored as one word.
    assign push_v = wr_ev & (~cfg_r.in_x9 | whalf_r);
    assign push_d = cfg_r.in_x9 ? {p.data[BYTE_W-1:0], wlo_r} : p.data;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            whalf_r <= 1'b0;
            wlo_r   <= '0;
        end else if (clr) begin
            whalf_r <= 1'b0;
        end else if (wr_ev && cfg_r.in_x9 && in_ready) begin
            whalf_r <= ~whalf_r;
            if (!whalf_r) begin
                wlo_r <= p.data[BYTE_W-1:0];
            end
        end
    end

    bmf_buf #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_buf (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clear     (clr),
        .in_valid  (push_v),
        .in_ready  (in_ready),
        .in_data   (push_d),
        .out_valid (avail),
        .out_ready (pop),
        .out_data  (word),
        .level     (level)
    );

    // A 9-bit reader sees the low byte, then the high byte, then the word is popped.
    assign unit = cfg_r.out_x9 ? {{(DATA_W-BYTE_W){1'b0}},
                                  (rhalf_r ? word[DATA_W-1:BYTE_W] : word[BYTE_W-1:0])} : word;

    // Standard mode loads only on a read; fall-through preloads the first unit.
    always_comb begin
        if (!cfg_r.fall_thru) begin
            take = rd_ev & avail;
        end else if (ov_r) begin
            take = rd_ev & avail;
        end else begin
            take = avail & rclk_rise & (fall_cnt_r == 2'(FALL_EDGES - 1));
        end
    end
    assign pop = take & (~cfg_r.out_x9 | rhalf_r);

    // Output register and read-side state.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            read_data_bus <= '0;
            rhalf_r       <= 1'b0;
            ov_r          <= 1'b0;
            fall_cnt_r    <= '0;
        end else if (clr) begin
            rhalf_r    <= 1'b0;
            ov_r       <= 1'b0;
            fall_cnt_r <= '0;
        end else begin
            if (take) begin
                read_data_bus <= unit;
                ov_r          <= 1'b1;
                if (cfg_r.out_x9) begin
                    rhalf_r <= ~rhalf_r;
                end
            end else if (cfg_r.fall_thru && rd_ev && ov_r) begin
                ov_r <= 1'b0;             // Last unit consumed; the next one falls through again.
            end
            if (ov_r || !avail || take) begin
                fall_cnt_r <= '0;
            end else if (rclk_rise) begin
                fall_cnt_r <= fall_cnt_r + 1'b1;
            end
        end
    end

    // Chip select follows the read clock, or the pin itself in asynchronous read.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_n_r <= 1'b1;
        end else if (cfg_r.async_r || rclk_rise) begin
            sel_n_r <= p.read_chip_select_n;
        end
    end

    // Output enable gates the pins combinationally so the float needs no clock.
    assign read_data_bus_oe = ~output_enable_n & ~sel_n_r;

    // Echo outputs are delayed copies of the read controls, held idle in asynchronous read.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            echo_read_clock    <= 1'b0;
            echo_read_enable_n <= 1'b1;
        end else if (cfg_r.async_r) begin
            echo_read_clock    <= 1'b0;
            echo_read_enable_n <= 1'b1;
        end else begin
            echo_read_clock <= p.rclk;
            if (rclk_rise) begin
                echo_read_enable_n <= p.read_enable_n;
            end
        end
    end

    // Flags, all active low, recomputed every cycle; all but the fall-through valid flag (from ov_r) come from the pointer distance.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            empty_flag_out_valid <= 1'b0;
            full_flag_in_ready   <= 1'b1;
            half_full_flag       <= 1'b1;
            almost_empty_flag    <= 1'b0;
            almost_full_flag     <= 1'b1;
        end else begin
            empty_flag_out_valid <= cfg_r.fall_thru ? ~ov_r : avail;
            full_flag_in_ready   <= cfg_r.fall_thru ? ~in_ready : in_ready;
            half_full_flag       <= ~(level > (AW+1)'(HALF_LVL));
            almost_empty_flag    <= ~(level <= (AW+1)'(AE_OFS));
            almost_full_flag     <= ~(level >= (AW+1)'(DEPTH - AF_OFS));
        end
    end
endmodule
`default_nettype wire

// ### dv/bmf_peer.sv
`timescale 1ns/1ns
`default_nettype none

// One port-clock period per request, after which the pin stands still as a stopped clock may.
module bmf_peer (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic go,
    output logic      pin,
    output logic      busy
);
    logic [3:0] cnt_r;

    // Four cycles high, then four low, keeps each phase above the two-cycle minimum.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 4'h0;
        end else if (go && cnt_r == 4'h0) begin
            cnt_r <= 4'h8;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    assign pin  = cnt_r > 4'h4;
    assign busy = cnt_r != 4'h0;
endmodule
`default_nettype wire

// ### dv/bmf_fifo_chk.sv
`timescale 1ns/1ns
`default_nettype none

// Pin checks on the buffer top; two ages count quiet cycles, one since the last read-port activity, one since activity on either port.
module bmf_fifo_chk (
    input wire logic                       sys_clk,
    input wire logic                       rst_b,
    input wire logic                       wclk,
    input wire logic                       wr_strobe,
    input wire logic                       rclk,
    input wire logic                       rd_strobe,
    input wire logic                       read_enable_n,
    input wire logic                       read_chip_select_n,
    input wire logic                       output_enable_n,
    input wire logic                       master_reset_n,
    input wire logic                       partial_reset_n,
    input wire logic [bmf_pkg::DATA_W-1:0] read_data_bus,
    input wire logic                       read_data_bus_oe,
    input wire logic                       echo_read_enable_n,
    input wire logic                       echo_read_clock,
    input wire logic                       half_full_flag,
    input wire logic                       almost_empty_flag,
    input wire logic                       almost_full_flag
);
    import bmf_pkg::*;
    logic [3:0] rd_age_r;
    logic [3:0] any_age_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Read data and level flags may only move shortly after a port edge or a reset pin, so a stray update shows.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_age_r  <= 4'h0;
            any_age_r <= 4'h0;
        end else begin
            rd_age_r  <= (rclk || rd_strobe || !master_reset_n) ? 4'h0 : rd_age_r + {3'h0, rd_age_r != 4'hf};
            any_age_r <= (wclk || wr_strobe || rclk || rd_strobe || !master_reset_n || !partial_reset_n) ?
                         4'h0 : any_age_r + {3'h0, any_age_r != 4'hf};
        end
    end

    a_oe_float: assert property (output_enable_n |-> !read_data_bus_oe)
        else $error("data outputs driven with output enable off");
    a_sel_float: assert property ($rose(rclk) && read_chip_select_n
        ##1 read_chip_select_n [*4] |-> !read_data_bus_oe)
        else $error("data outputs driven with chip select off");
    a_sel_drive: assert property ($rose(rclk) && !read_chip_select_n
        ##1 (!read_chip_select_n && !output_enable_n) [*4] |-> read_data_bus_oe)
        else $error("data outputs not driven when selected");
    a_echo_clock: assert property ($rose(rclk) |-> ##[2:4] $rose(echo_read_clock))
        else $error("echo clock did not follow read clock");
    a_echo_idle: assert property ($rose(rclk) && read_enable_n
        ##1 read_enable_n [*5] |-> echo_read_enable_n)
        else $error("echo enable active without read enable");
    a_echo_active: assert property ($rose(rclk) && !read_enable_n
        ##1 !read_enable_n [*5] |-> !echo_read_enable_n)
        else $error("echo enable missing after read enable");
    a_half_empty: assert property (!half_full_flag |-> almost_empty_flag)
        else $error("half full and almost empty together");
    a_full_half: assert property (!almost_full_flag |-> !half_full_flag)
        else $error("almost full without half full");
    a_data_cause: assert property ($changed(read_data_bus) |-> rd_age_r <= 4'h2)
        else $error("read data moved without a read");
    a_flag_cause: assert property ($changed({half_full_flag, almost_empty_flag, almost_full_flag})
        |-> any_age_r <= 4'h5)
        else $error("level flags moved without port activity");
endmodule

bind bmf_fifo bmf_fifo_chk chk (.*);
`default_nettype wire

// ### dv/test_bmf_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module test_bmf_fifo;
    import bmf_pkg::*;
    logic              sys_clk, rst_b, wclk, wr_strobe, rclk, rd_strobe, write_enable_n, read_enable_n;
    logic              read_chip_select_n, output_enable_n, master_reset_n, partial_reset_n, input_width_select;
    logic              output_width_select, fallthrough_mode_serial_in, async_write_sel, async_read_sel;
    logic              read_data_bus_oe, echo_read_enable_n, echo_read_clock, empty_flag_out_valid;
    logic              full_flag_in_ready, half_full_flag, almost_empty_flag, almost_full_flag;
    logic              wpin, rpin, w_go, r_go, w_busy, r_busy;
    logic [DATA_W-1:0] write_data_bus, read_data_bus;
    int                failures = 0;
    int                tests_run = 0;
    int                i;

    bmf_fifo dut (.*);
    bmf_peer wr_peer (.sys_clk(sys_clk), .rst_b(rst_b), .go(w_go), .pin(wpin), .busy(w_busy));
    bmf_peer rd_peer (.sys_clk(sys_clk), .rst_b(rst_b), .go(r_go), .pin(rpin), .busy(r_busy));

    // One generator per port feeds either the clock or the strobe, as the timing straps choose.
    assign wclk      = wpin & ~async_write_sel;
    assign wr_strobe = wpin & async_write_sel;
    assign rclk      = rpin & ~async_read_sel;
    assign rd_strobe = rpin & async_read_sel;

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic flags(input logic [4:0] exp);
        chk("flags", {13'h0, exp}, {13'h0, empty_flag_out_valid, full_flag_in_ready, half_full_flag,
            almost_empty_flag, almost_full_flag});
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One port period; the enable and data are held until four cycles after the pin period is over, then released.
    task automatic port(input logic wr, input logic en_n, input logic [DATA_W-1:0] d);
        int n;
        if (wr) begin
            write_data_bus = d;
            write_enable_n = en_n;
            w_go = 1'b1;
        end else begin
            read_enable_n = en_n;
            r_go = 1'b1;
        end
        cyc(1);
        w_go = 1'b0;
        r_go = 1'b0;
        for (n = 0; n < 20 && (w_busy || r_busy); n++) cyc(1);
        if (n == 20) begin
            failures++;
            end_of_test();
        end
        cyc(4);
        write_data_bus = ~d;
        write_enable_n = ~async_write_sel;
        read_enable_n  = ~async_read_sel;
        // Let one edge pass so that a following call never reassigns these pins in the same step.
        cyc(1);
    endtask

    // Straps are held steady across the whole master reset pulse.
    task automatic mreset(input logic [4:0] c);
        {input_width_select, output_width_select, fallthrough_mode_serial_in, async_write_sel, async_read_sel} = c;
        master_reset_n = 1'b0;
        cyc(6);
        master_reset_n = 1'b1;
        write_enable_n = ~c[1];
        read_enable_n  = ~c[0];
        cyc(6);
    endtask

    initial begin
        {rst_b, w_go, r_go, write_enable_n, read_enable_n, read_chip_select_n, output_enable_n} = 7'h0c;
        {master_reset_n, partial_reset_n, input_width_select, output_width_select} = 4'hc;
        {fallthrough_mode_serial_in, async_write_sel, async_read_sel, write_data_bus} = '0;
        cyc(6);
        rst_b = 1'b1;
        cyc(2);
        mreset(5'h00);
        flags(5'h0d);
        port(1'b1, 1'b0, 18'h1a5a5);
        chk("data", 18'h00000, read_data_bus);
        flags(5'h1d);
        port(1'b0, 1'b0, 18'h0);
        chk("data", 18'h1a5a5, read_data_bus);
        port(1'b0, 1'b0, 18'h0);
        chk("data", 18'h1a5a5, read_data_bus);
        output_enable_n = 1'b1;
        cyc(1);
        chk("oe", 18'h0, {17'h0, read_data_bus_oe});
        output_enable_n = 1'b0;
        read_chip_select_n = 1'b1;
        port(1'b0, 1'b1, 18'h0);
        chk("oe", 18'h0, {17'h0, read_data_bus_oe});
        read_chip_select_n = 1'b0;
        port(1'b0, 1'b1, 18'h0);
        chk("oe", 18'h1, {17'h0, read_data_bus_oe});
        $display("test standard done");
        for (i = 0; i < 17; i++) port(1'b1, 1'b0, 18'h00100 + 18'(i));
        flags(5'h12);
        for (i = 0; i < 17; i++) begin
            port(1'b0, 1'b0, 18'h0);
            chk("data", 18'h00100 + 18'(i < 16 ? i : 15), read_data_bus);
            if (i == 6) flags(5'h1b);
            if (i == 13) flags(5'h1d);
        end
        flags(5'h0d);
        $display("test fill done");
        for (i = 0; i < 3; i++) port(1'b1, 1'b0, 18'h2aaaa);
        partial_reset_n = 1'b0;
        cyc(6);
        partial_reset_n = 1'b1;
        cyc(6);
        flags(5'h0d);
        port(1'b1, 1'b0, 18'h15555);
        chk("data", 18'h0010f, read_data_bus);
        port(1'b0, 1'b0, 18'h0);
        chk("data", 18'h15555, read_data_bus);
        $display("test partial done");
        mreset(5'h04);
        flags(5'h15);
        port(1'b1, 1'b0, 18'h33333);
        for (i = 0; i < 2; i++) port(1'b0, 1'b1, 18'h0);
        chk("data", 18'h15555, read_data_bus);
        port(1'b0, 1'b1, 18'h0);
        chk("data", 18'h33333, read_data_bus);
        chk("valid", 18'h0, {17'h0, empty_flag_out_valid});
        port(1'b1, 1'b0, 18'h0cccc);
        port(1'b0, 1'b1, 18'h0);
        chk("data", 18'h33333, read_data_bus);
        port(1'b0, 1'b0, 18'h0);
        chk("data", 18'h0cccc, read_data_bus);
        port(1'b0, 1'b0, 18'h0);
        chk("valid", 18'h1, {17'h0, empty_flag_out_valid});
        // A partial reset with the mode pin now low must keep fall-through flag meanings.
        fallthrough_mode_serial_in = 1'b0;
        partial_reset_n = 1'b0;
        cyc(6);
        partial_reset_n = 1'b1;
        cyc(6);
        flags(5'h15);
        $display("test fall through done");
        mreset(5'h10);
        port(1'b1, 1'b0, 18'h000a5);
        port(1'b1, 1'b0, 18'h0015a);
        port(1'b0, 1'b0, 18'h0);
        chk("data", 18'h2b4a5, read_data_bus);
        mreset(5'h08);
        port(1'b1, 1'b0, 18'h2b4c3);
        port(1'b0, 1'b0, 18'h0);
        chk("data", 18'h000c3, read_data_bus);
        port(1'b0, 1'b0, 18'h0);
        chk("data", 18'h0015a, read_data_bus);
        $display("test widths done");
        mreset(5'h03);
        port(1'b1, 1'b0, 18'h3c3c3);
        port(1'b0, 1'b0, 18'h0);
        chk("data", 18'h3c3c3, read_data_bus);
        chk("echo", 18'h1, {16'h0, echo_read_clock, echo_read_enable_n});
        $display("test async done");
        end_of_test();
    end
endmodule
`default_nettype wire
